// ==== design/plc_regs.vh ====
// Register map, field positions and reset values of the PHY config bank
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

// Register indices (byte address is four times the index)
`define PLC_IDX_INT_STATUS  8'h10
`define PLC_IDX_INT_MASK    8'h11
`define PLC_IDX_LOOPBACK    8'h12
`define PLC_IDX_GLOBAL_CFG  8'h13
`define PLC_IDX_STA_LOW     8'h16
`define PLC_IDX_STA_MID     8'h17
`define PLC_IDX_STA_HIGH    8'h18
`define PLC_IDX_CTRL        8'h20
`define PLC_IDX_MEDIA_STAT  8'h21

// Reset values
`define PLC_RST_ZERO        16'h0000
`define PLC_RST_GLOBAL_CFG  16'h0102

// Last count of the strap window; three sync stages must pass the pins
`define PLC_STRAP_LAST      3'h5

// Writable-bit masks; reserved bits stay at reset value
`define PLC_WMASK_LOOPBACK  16'hBC80
`define PLC_WMASK_GLOBAL    16'h3F83
`define PLC_WMASK_INT       16'hF000
`define PLC_WMASK_CTRL      16'h0003

// Loopback control fields
`define PLC_LB_MEDIA_MAC    15
`define PLC_LB_CODING_MAC   13
`define PLC_LB_ATTACH_MAC   12
`define PLC_LB_FRONT_MAC    11
`define PLC_LB_GEN_CHK      10
`define PLC_LB_MEDIA_PHY    7

// Global configuration fields
`define PLC_GC_TXC_INV      13
`define PLC_GC_RXC_INV      12
`define PLC_GC_FIBER        11
`define PLC_GC_WOL_EN       10
`define PLC_GC_FORCE_LINK   9
`define PLC_GC_WOL_BCAST    8
`define PLC_GC_WOL_PSWD     7
`define PLC_GC_XMODE_HI     1
`define PLC_GC_XMODE_LO     0

// Interrupt status and mask fields
`define PLC_INT_LINK_CHG    15
`define PLC_INT_WAKE        14
`define PLC_INT_TX_LPI      13
`define PLC_INT_RX_LPI      12

// Own control register fields
`define PLC_CTRL_AUTONEG    0
`define PLC_CTRL_USE_INT    1

// Crossover mode encodings
`define PLC_XMODE_STRAIGHT  2'b00
`define PLC_XMODE_CROSS     2'b01
`define PLC_XMODE_AUTO      2'b10

`endif

// ==== design/plc_sync3.v ====
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module plc_sync3
#(
   parameter WIDTH = 1
)
(
   input  wire             clk_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] async_i,
   output reg  [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;
   integer         k;

   // Shift chain; only s2/s3 feed the agreement logic
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         s1_r   <= {WIDTH{1'b0}};
         s2_r   <= {WIDTH{1'b0}};
         s3_r   <= {WIDTH{1'b0}};
         sync_o <= {WIDTH{1'b0}};
      end
      else
      begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (k = 0; k < WIDTH; k = k + 1)
            if (s2_r[k] == s3_r[k])
               sync_o[k] <= s3_r[k];
      end
   end
endmodule
`default_nettype wire

// ==== design/plc_event_flags.v ====
// Sticky event flags with write-one-to-clear; a set beats a clear
`timescale 1ns/1ns
`default_nettype none
module plc_event_flags
#(
   parameter WIDTH = 4
)
(
   input  wire             clk_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] set_i,
   input  wire [WIDTH-1:0] clr_i,
   output reg  [WIDTH-1:0] flag_o
);
   genvar g;

   // One flop per flag
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_flag
         always @(posedge clk_i)
         begin
            if (!rst_b_i)
               flag_o[g] <= 1'b0;
            else if (set_i[g])
               flag_o[g] <= 1'b1;
            else if (clr_i[g])
               flag_o[g] <= 1'b0;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== design/plc_config_regs.v ====
// PHY loopback, clocking, medium, wake and station address config bank
//
// Functional notes
// - Masked RX idle status drives low interrupt
// - Bits 15,13,12,11 enable loops to MAC
// - Bit 10 loops generator into checker
// - Bit 7 loops MAC interface, internal PHY
// - Bit 13 inverts transmit clock
// - Bit 12 inverts receive clock
// - Fiber bit OR fiber pin selects medium
// - Bit 10 enables magic packet detection
// - Bit 9 forces both speeds link up
// - Force link acts only in forced speed
// - Enabling auto-negotiation clears force link bit
// - Bit 8 accepts broadcast magic packets
// - Bit 7 requires password check
// - Crossover field: straight, cross, auto, reserved
// - Strap pins latched into crossover field
// - Loopback or fiber forces straight crossover
// - Address bytes 0,1 in first register
// - Address bytes 2,3 in second register
// - Magic packet sets wake status bit 14
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "plc_regs.vh"
module plc_config_regs
(
   // Clock and reset
   input  wire        CLK_I,
   input  wire        RST_B_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output wire        PREADY_O,
   output reg  [31:0] PRDATA_O,
   output wire        PSLVERR_O,
   // Pins from outside the clock domain
   input  wire        FIBER_SELECT_PIN_I,
   input  wire        DUPLEX_COLLISION_LED_PIN_I,
   input  wire        RECEIVE_ERROR_PIN_I,
   // Events from PHY logic on this clock
   input  wire        LINK_CHANGE_EV_I,
   input  wire        TX_LPI_EV_I,
   input  wire        RX_LPI_EV_I,
   input  wire        MAGIC_PACKET_EV_I,
   // Controls toward the PHY datapath
   output reg         LOOP_MEDIA_IF_TO_MAC_EN_O,
   output reg         LOOP_CODING_SUBLAYER_TO_MAC_EN_O,
   output reg         LOOP_ATTACHMENT_TO_MAC_EN_O,
   output reg         LOOP_FRONTEND_TO_MAC_EN_O,
   output reg         LOOP_GENERATOR_TO_CHECKER_EN_O,
   output reg         LOOP_MEDIA_IF_TO_PHY_EN_O,
   output reg         TX_CLOCK_INVERT_O,
   output reg         RX_CLOCK_INVERT_O,
   output reg         FIBER_MODE_O,
   output reg         WAKE_ON_LAN_ENABLE_O,
   output reg         WAKE_ACCEPT_BROADCAST_O,
   output reg         WAKE_PASSWORD_CHECK_O,
   output reg         FORCE_LINK_10_O,
   output reg         FORCE_LINK_100_O,
   output reg  [1:0]  CROSSOVER_MODE_O,
   output reg  [47:0] STATION_ADDR_O,
   // Interrupts, active low
   output reg         INTERNAL_MGMT_IRQ_N_O,
   output reg         EXTERNAL_MGMT_IRQ_N_O
);
   // Register storage
   reg  [15:0] loopback_r;
   reg  [15:0] global_cfg_r;
   reg  [15:0] int_mask_r;
   reg  [15:0] ctrl_r;
   reg  [15:0] sta_low_r;
   reg  [15:0] sta_mid_r;
   reg  [15:0] sta_high_r;
   reg         strap_done_r;
   reg         autoneg_d_r;
   // Combinational next values
   reg  [15:0] global_cfg_nxt;
   reg  [15:0] rdata_nxt;
   // Synchronised pins and event flags
   wire [2:0]  pins_sync;
   wire        fiber_pin_s;
   wire        dup_led_s;
   wire        rx_err_s;
   wire [3:0]  flags;
   wire [3:0]  flag_set;
   wire [3:0]  flag_clr;
   // Bus decode
   wire [9:0]  idx;
   wire        wr_en;
   wire        rd_en;
   wire        hit;
   wire        sel_status;
   wire        sel_mask;
   wire        sel_loop;
   wire        sel_global;
   wire        sel_sta_low;
   wire        sel_sta_mid;
   wire        sel_sta_high;
   wire        sel_ctrl;
   wire        sel_media;
   // Derived state
   wire        any_loop;
   wire        fiber;
   wire        autoneg_rise;

   // Pins cross into the clock domain
   plc_sync3 #(.WIDTH(3)) u_sync
   (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .async_i ({FIBER_SELECT_PIN_I, DUPLEX_COLLISION_LED_PIN_I,
                 RECEIVE_ERROR_PIN_I}),
      .sync_o  (pins_sync)
   );

   // Pin bits by name; the straps read two of them once after reset
   assign fiber_pin_s = pins_sync[2];
   assign dup_led_s   = pins_sync[1];
   assign rx_err_s    = pins_sync[0];

   // APB decode; zero wait states, word aligned index
   assign idx      = PADDR_I[11:2];
   assign PREADY_O = 1'b1;
   assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
   // Reads are looked up in the setup phase
   assign rd_en    = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   // One select per mapped index
   assign sel_status   = (idx == {2'b00, `PLC_IDX_INT_STATUS});
   assign sel_mask     = (idx == {2'b00, `PLC_IDX_INT_MASK});
   assign sel_loop     = (idx == {2'b00, `PLC_IDX_LOOPBACK});
   assign sel_global   = (idx == {2'b00, `PLC_IDX_GLOBAL_CFG});
   assign sel_sta_low  = (idx == {2'b00, `PLC_IDX_STA_LOW});
   assign sel_sta_mid  = (idx == {2'b00, `PLC_IDX_STA_MID});
   assign sel_sta_high = (idx == {2'b00, `PLC_IDX_STA_HIGH});
   assign sel_ctrl     = (idx == {2'b00, `PLC_IDX_CTRL});
   assign sel_media    = (idx == {2'b00, `PLC_IDX_MEDIA_STAT});
   assign hit = sel_status | sel_mask | sel_loop | sel_global
              | sel_sta_low | sel_sta_mid | sel_sta_high
              | sel_ctrl | sel_media;
   // Unmapped addresses answer with an error, no side effect
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

   // Event flags, write one to clear
   assign flag_set = {LINK_CHANGE_EV_I, MAGIC_PACKET_EV_I,
                      TX_LPI_EV_I, RX_LPI_EV_I};
   // An event in the clear cycle keeps its flag set
   assign flag_clr = (wr_en && sel_status) ?
                     PWDATA_I[15:12] : 4'b0000;

   plc_event_flags #(.WIDTH(4)) u_flags
   (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .set_i   (flag_set),
      .clr_i   (flag_clr),
      .flag_o  (flags)
   );

   // Derived medium and loop state
   assign fiber = global_cfg_r[`PLC_GC_FIBER] | fiber_pin_s;
   // Loop to PHY only counts while the internal PHY is in use
   assign any_loop = loopback_r[`PLC_LB_MEDIA_MAC]
                   | loopback_r[`PLC_LB_CODING_MAC]
                   | loopback_r[`PLC_LB_ATTACH_MAC]
                   | loopback_r[`PLC_LB_FRONT_MAC]
                   | loopback_r[`PLC_LB_GEN_CHK]
                   | (loopback_r[`PLC_LB_MEDIA_PHY]
                      & ctrl_r[`PLC_CTRL_USE_INT]);
   assign autoneg_rise = ctrl_r[`PLC_CTRL_AUTONEG] & ~autoneg_d_r;

   // Next global config: write, strap capture, force-link auto clear
   always @*
   begin
      global_cfg_nxt = global_cfg_r;
      if (wr_en && sel_global)
         global_cfg_nxt = (global_cfg_r & ~`PLC_WMASK_GLOBAL)
                        | (PWDATA_I[15:0] & `PLC_WMASK_GLOBAL);
      // Straps caught once, after synchroniser has settled
      if (!strap_done_r)
      begin
         global_cfg_nxt[`PLC_GC_XMODE_HI] = dup_led_s;
         global_cfg_nxt[`PLC_GC_XMODE_LO] = rx_err_s;
      end
      // Hardware drops a force request left over from forced mode
      if (autoneg_rise)
         global_cfg_nxt[`PLC_GC_FORCE_LINK] = 1'b0;
   end

   // Strap window: a few cycles so the three-stage sync has passed pins
   reg [2:0] strap_cnt_r;
   always @(posedge CLK_I)
   begin
      if (!RST_B_I)
      begin
         strap_cnt_r  <= 3'd0;
         strap_done_r <= 1'b0;
      end
      else if (!strap_done_r)
      begin
         strap_cnt_r <= strap_cnt_r + 3'd1;
         if (strap_cnt_r == `PLC_STRAP_LAST)
            strap_done_r <= 1'b1;
      end
   end

   // Register writes; reserved bits kept by masks
   always @(posedge CLK_I)
   begin
      if (!RST_B_I)
      begin
         loopback_r   <= `PLC_RST_ZERO;
         global_cfg_r <= `PLC_RST_GLOBAL_CFG;
         int_mask_r   <= `PLC_RST_ZERO;
         ctrl_r       <= `PLC_RST_ZERO;
         sta_low_r    <= `PLC_RST_ZERO;
         sta_mid_r    <= `PLC_RST_ZERO;
         sta_high_r   <= `PLC_RST_ZERO;
         autoneg_d_r  <= 1'b0;
      end
      else
      begin
         global_cfg_r <= global_cfg_nxt;
         autoneg_d_r  <= ctrl_r[`PLC_CTRL_AUTONEG];
         // Status clears go to the flag block; media status is read-only
         if (wr_en)
         begin
            case (idx)
               {2'b00, `PLC_IDX_LOOPBACK}:
                  loopback_r <= PWDATA_I[15:0] & `PLC_WMASK_LOOPBACK;
               {2'b00, `PLC_IDX_INT_MASK}:
                  int_mask_r <= PWDATA_I[15:0] & `PLC_WMASK_INT;
               {2'b00, `PLC_IDX_CTRL}:
                  ctrl_r <= PWDATA_I[15:0] & `PLC_WMASK_CTRL;
               {2'b00, `PLC_IDX_STA_LOW}:
                  sta_low_r <= PWDATA_I[15:0];
               {2'b00, `PLC_IDX_STA_MID}:
                  sta_mid_r <= PWDATA_I[15:0];
               {2'b00, `PLC_IDX_STA_HIGH}:
                  sta_high_r <= PWDATA_I[15:0];
               default:
                  ;
            endcase
         end
      end
   end

   // Read mux; upper half-word reads zero
   always @*
   begin
      case (idx)
         {2'b00, `PLC_IDX_INT_STATUS}: rdata_nxt = {flags, 12'h000};
         {2'b00, `PLC_IDX_INT_MASK}:   rdata_nxt = int_mask_r;
         {2'b00, `PLC_IDX_LOOPBACK}:   rdata_nxt = loopback_r;
         {2'b00, `PLC_IDX_GLOBAL_CFG}: rdata_nxt = global_cfg_r;
         {2'b00, `PLC_IDX_STA_LOW}:    rdata_nxt = sta_low_r;
         {2'b00, `PLC_IDX_STA_MID}:    rdata_nxt = sta_mid_r;
         {2'b00, `PLC_IDX_STA_HIGH}:   rdata_nxt = sta_high_r;
         {2'b00, `PLC_IDX_CTRL}:       rdata_nxt = ctrl_r;
         {2'b00, `PLC_IDX_MEDIA_STAT}:
            rdata_nxt = {12'h000, any_loop, fiber, CROSSOVER_MODE_O};
         default:                       rdata_nxt = `PLC_RST_ZERO;
      endcase
   end

   // Read data is caught from the mux at the setup edge, so it stands
   // through the access phase with no wait state; a flag that sets in
   // the access cycle itself shows on the next read
   always @(posedge CLK_I)
   begin
      if (!RST_B_I)
         PRDATA_O <= 32'h0000_0000;
      else if (rd_en)
         PRDATA_O <= {16'h0000, rdata_nxt};
   end

   // Registered controls toward the datapath
   always @(posedge CLK_I)
   begin
      if (!RST_B_I)
      begin
         LOOP_MEDIA_IF_TO_MAC_EN_O        <= 1'b0;
         LOOP_CODING_SUBLAYER_TO_MAC_EN_O <= 1'b0;
         LOOP_ATTACHMENT_TO_MAC_EN_O      <= 1'b0;
         LOOP_FRONTEND_TO_MAC_EN_O        <= 1'b0;
         LOOP_GENERATOR_TO_CHECKER_EN_O   <= 1'b0;
         LOOP_MEDIA_IF_TO_PHY_EN_O        <= 1'b0;
         TX_CLOCK_INVERT_O                <= 1'b0;
         RX_CLOCK_INVERT_O                <= 1'b0;
         FIBER_MODE_O                     <= 1'b0;
         WAKE_ON_LAN_ENABLE_O             <= 1'b0;
         WAKE_ACCEPT_BROADCAST_O          <= 1'b0;
         WAKE_PASSWORD_CHECK_O            <= 1'b0;
         FORCE_LINK_10_O                  <= 1'b0;
         FORCE_LINK_100_O                 <= 1'b0;
         CROSSOVER_MODE_O                 <= `PLC_XMODE_AUTO;
         STATION_ADDR_O                   <= 48'h0000_0000_0000;
         INTERNAL_MGMT_IRQ_N_O            <= 1'b1;
         EXTERNAL_MGMT_IRQ_N_O            <= 1'b1;
      end
      else
      begin
         // Loop enables follow the loopback register one edge later
         LOOP_MEDIA_IF_TO_MAC_EN_O <= loopback_r[`PLC_LB_MEDIA_MAC];
         LOOP_CODING_SUBLAYER_TO_MAC_EN_O <=
            loopback_r[`PLC_LB_CODING_MAC];
         LOOP_ATTACHMENT_TO_MAC_EN_O <= loopback_r[`PLC_LB_ATTACH_MAC];
         LOOP_FRONTEND_TO_MAC_EN_O <= loopback_r[`PLC_LB_FRONT_MAC];
         LOOP_GENERATOR_TO_CHECKER_EN_O <= loopback_r[`PLC_LB_GEN_CHK];
         // Only meaningful with the internal PHY in the path
         LOOP_MEDIA_IF_TO_PHY_EN_O <= loopback_r[`PLC_LB_MEDIA_PHY]
                                    & ctrl_r[`PLC_CTRL_USE_INT];
         // Clock inversion and medium
         TX_CLOCK_INVERT_O <= global_cfg_r[`PLC_GC_TXC_INV];
         RX_CLOCK_INVERT_O <= global_cfg_r[`PLC_GC_RXC_INV];
         FIBER_MODE_O <= fiber;
         // Wake controls go to the frame matcher
         WAKE_ON_LAN_ENABLE_O <= global_cfg_r[`PLC_GC_WOL_EN];
         WAKE_ACCEPT_BROADCAST_O <= global_cfg_r[`PLC_GC_WOL_BCAST];
         WAKE_PASSWORD_CHECK_O <= global_cfg_r[`PLC_GC_WOL_PSWD];
         // Forcing ignored while auto-negotiation runs
         // Both speeds are forced together from one bit
         FORCE_LINK_10_O <= global_cfg_r[`PLC_GC_FORCE_LINK]
                          & ~ctrl_r[`PLC_CTRL_AUTONEG];
         FORCE_LINK_100_O <= global_cfg_r[`PLC_GC_FORCE_LINK]
                           & ~ctrl_r[`PLC_CTRL_AUTONEG];
         // Reserved code 11 is passed as written; datapath treats it
         if (any_loop | fiber)
            CROSSOVER_MODE_O <= `PLC_XMODE_STRAIGHT;
         else
            CROSSOVER_MODE_O <=
               global_cfg_r[`PLC_GC_XMODE_HI:`PLC_GC_XMODE_LO];
         // Matcher compares against all six bytes in transmit order
         STATION_ADDR_O <= {sta_low_r, sta_mid_r, sta_high_r};
         // Both interrupt pins carry the same masked OR
         INTERNAL_MGMT_IRQ_N_O <= ~|(flags & int_mask_r[15:12]);
         EXTERNAL_MGMT_IRQ_N_O <= ~|(flags & int_mask_r[15:12]);
      end
   end
endmodule
`default_nettype wire

// ==== tb/plc_far_end.sv ====
// Far-side PHY logic model: turns event requests into one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module plc_far_end
(
   // Clock
   input  wire logic       clk_i,
   // Requests {link, magic, tx idle, rx idle}, held as levels
   input  wire logic [3:0] fire_i,
   // Pulses toward the bank
   output logic      [3:0] ev_o
);
   logic [3:0] seen_r;

   initial
   begin
      seen_r = 4'h0;
      ev_o   = 4'h0;
   end

   // Edge detect so a held request gives exactly one pulse
   always @(posedge clk_i)
   begin
      seen_r <= fire_i;
      ev_o   <= fire_i & ~seen_r;
   end
endmodule
`default_nettype wire

// ==== tb/plc_config_regs_monitor.sv ====
// Port-level assertions for the PHY configuration bank
`timescale 1ns/1ns
`default_nettype none
module plc_config_regs_monitor
(
   // Clock, reset and bus
   input wire logic        CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I, PRDATA_O,
   input wire logic        PREADY_O, PSLVERR_O,
   // Controls
   input wire logic        LOOP_MEDIA_IF_TO_MAC_EN_O,
   input wire logic        LOOP_GENERATOR_TO_CHECKER_EN_O,
   input wire logic        TX_CLOCK_INVERT_O, RX_CLOCK_INVERT_O,
   input wire logic        FIBER_MODE_O, WAKE_ON_LAN_ENABLE_O,
   input wire logic        FORCE_LINK_10_O, FORCE_LINK_100_O,
   input wire logic [1:0]  CROSSOVER_MODE_O,
   input wire logic        INTERNAL_MGMT_IRQ_N_O, EXTERNAL_MGMT_IRQ_N_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   // Completed accesses; writes land at the access edge
   wire       acc = PSEL_I & PENABLE_I;
   wire       wgc = acc & PWRITE_I & (PADDR_I == 12'h04C);
   wire       wlb = acc & PWRITE_I & (PADDR_I == 12'h048);
   wire [9:0] ix  = PADDR_I[11:2];
   wire       hit = ix inside {10'h010, 10'h011, 10'h012, 10'h013, 10'h016,
                               10'h017, 10'h018, 10'h020, 10'h021};

   a_txc_follow: assert property (wgc |-> ##2
      TX_CLOCK_INVERT_O == $past(PWDATA_I[13], 2)) else $error("tx inv");
   a_rxc_follow: assert property (wgc |-> ##2
      RX_CLOCK_INVERT_O == $past(PWDATA_I[12], 2)) else $error("rx inv");
   a_wake_follow: assert property (wgc |-> ##2
      WAKE_ON_LAN_ENABLE_O == $past(PWDATA_I[10], 2)) else $error("wake");
   a_loop_mac: assert property (wlb |-> ##2
      LOOP_MEDIA_IF_TO_MAC_EN_O == $past(PWDATA_I[15], 2)) else $error("lb");
   a_loop_gen: assert property (wlb |-> ##2
      LOOP_GENERATOR_TO_CHECKER_EN_O == $past(PWDATA_I[10], 2))
      else $error("gen loop");
   a_xover_straight: assert property ((LOOP_MEDIA_IF_TO_MAC_EN_O ||
      LOOP_GENERATOR_TO_CHECKER_EN_O || FIBER_MODE_O) |-> ##[0:1]
      CROSSOVER_MODE_O == 2'b00) else $error("crossover not straight");
   a_force_pair: assert property (FORCE_LINK_10_O == FORCE_LINK_100_O)
      else $error("force link pair differs");
   a_irq_pair: assert property (
      INTERNAL_MGMT_IRQ_N_O == EXTERNAL_MGMT_IRQ_N_O) else $error("irq pair");
   a_unmapped_err: assert property (acc && !hit |-> PSLVERR_O)
      else $error("no error on unmapped index");
   a_ready_high: assert property (acc |-> PREADY_O) else $error("no ready");
   a_upper_zero: assert property (acc && !PWRITE_I |->
      PRDATA_O[31:16] == 16'h0000) else $error("upper read bits");
   a_reset_out: assert property (disable iff (1'b0) !RST_B_I |=>
      INTERNAL_MGMT_IRQ_N_O && !TX_CLOCK_INVERT_O) else $error("reset out");
endmodule

bind plc_config_regs plc_config_regs_monitor mon_u (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the PHY configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "plc_regs.vh"
module tb_top;
   logic        clk, rst_b, psel, pen, pwr, fib_pin, dup_pin, rxe_pin, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, d, v;
   logic [3:0]  fire;
   logic [15:0] lb_s, gc_s;
   logic [1:0]  ct_s;
   int          err_count, checks;
   wire         prdy, perr, lb_mac, lb_pcs, lb_pma, lb_afe, lb_gen, lb_phy;
   wire         txc, rxc, fib, wol, wbc, wpw, f10, f100, irqi, irqe;
   wire [1:0]   xm;
   wire [3:0]   ev;
   wire [31:0]  prdata;
   wire [47:0]  sta;
   wire [15:0]  ctl = {lb_mac, lb_pcs, lb_pma, lb_afe, lb_gen, lb_phy, txc,
                       rxc, fib, wol, wbc, wpw, f10, f100, xm};

   plc_far_end far_u (.clk_i(clk), .fire_i(fire), .ev_o(ev));
   plc_config_regs dut_u (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PREADY_O(prdy), .PRDATA_O(prdata), .PSLVERR_O(perr),
      .FIBER_SELECT_PIN_I(fib_pin), .DUPLEX_COLLISION_LED_PIN_I(dup_pin),
      .RECEIVE_ERROR_PIN_I(rxe_pin), .LINK_CHANGE_EV_I(ev[3]),
      .MAGIC_PACKET_EV_I(ev[2]), .TX_LPI_EV_I(ev[1]), .RX_LPI_EV_I(ev[0]),
      .LOOP_MEDIA_IF_TO_MAC_EN_O(lb_mac),
      .LOOP_CODING_SUBLAYER_TO_MAC_EN_O(lb_pcs),
      .LOOP_ATTACHMENT_TO_MAC_EN_O(lb_pma),
      .LOOP_FRONTEND_TO_MAC_EN_O(lb_afe),
      .LOOP_GENERATOR_TO_CHECKER_EN_O(lb_gen),
      .LOOP_MEDIA_IF_TO_PHY_EN_O(lb_phy), .TX_CLOCK_INVERT_O(txc),
      .RX_CLOCK_INVERT_O(rxc), .FIBER_MODE_O(fib),
      .WAKE_ON_LAN_ENABLE_O(wol), .WAKE_ACCEPT_BROADCAST_O(wbc),
      .WAKE_PASSWORD_CHECK_O(wpw), .FORCE_LINK_10_O(f10),
      .FORCE_LINK_100_O(f100), .CROSSOVER_MODE_O(xm), .STATION_ADDR_O(sta),
      .INTERNAL_MGMT_IRQ_N_O(irqi), .EXTERNAL_MGMT_IRQ_N_O(irqe));

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected control outputs from the shadow registers and the fiber pin
   function automatic [15:0] exp_ctl();
      logic fb, fl, any;
      fb  = gc_s[11] | fib_pin;
      fl  = gc_s[9] & ~ct_s[0];
      any = (|(lb_s & 16'hBC00)) | (lb_s[7] & ct_s[1]);
      return {lb_s[15], lb_s[13], lb_s[12], lb_s[11], lb_s[10],
              lb_s[7] & ct_s[1], gc_s[13], gc_s[12], fb, gc_s[10], gc_s[8],
              gc_s[7], fl, fl, (any | fb) ? 2'b00 : gc_s[1:0]};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; held until pready is seen with the access phase
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [15:0] wd);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= {16'h0000, wd};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      d = prdata;
      e = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   // Write, track shadows, let outputs settle, compare controls
   task automatic put(input logic [11:0] a, input logic [15:0] wd);
      apb(1'b1, a, wd);
      if (a == 12'h048) lb_s = wd & `PLC_WMASK_LOOPBACK;
      if (a == 12'h04C) gc_s = wd & `PLC_WMASK_GLOBAL;
      if (a == 12'h080)
      begin
         if (wd[0] & ~ct_s[0]) gc_s[9] = 1'b0;
         ct_s = wd[1:0];
      end
      repeat (8) @(posedge clk);
      chk(ctl, exp_ctl());
   endtask

   task automatic pulse(input logic [3:0] f);
      fire <= f;
      repeat (2) @(posedge clk);
      fire <= 4'h0;
      repeat (4) @(posedge clk);
   endtask

   task automatic complete_run();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end

   initial
   begin
      {rst_b, psel, pen, pwr, fib_pin, dup_pin, fire, paddr, pwdata} = '0;
      rxe_pin = 1'b1;
      {lb_s, ct_s, gc_s} = {16'h0000, 2'b00, 16'h0101};
      void'($urandom(7167));
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge clk);
      apb(1'b0, 12'h04C, 16'h0000);
      chk(d[15:0], 16'h0101);
      chk(ctl, exp_ctl());
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, (i == 0) ? 12'h048 : 12'h054 + 12'(i) * 12'h004,
             16'h0000);
         chk(d[15:0], 16'h0000);
      end
      apb(1'b0, 12'h03C, 16'h0000);
      chk({e, d[14:0]}, 16'h8000);
      $display("done reset and map");
      repeat (6)
      begin
         v = $urandom;
         put(12'h048, v[15:0]);
         apb(1'b0, 12'h048, 16'h0000);
         chk(d[15:0], v[15:0] & `PLC_WMASK_LOOPBACK);
      end
      put(12'h048, 16'h0000);
      repeat (6)
      begin
         v = $urandom;
         put(12'h04C, v[15:0]);
         apb(1'b0, 12'h04C, 16'h0000);
         chk(d[15:0], v[15:0] & `PLC_WMASK_GLOBAL);
      end
      for (int m = 0; m < 4; m++) put(12'h04C, 16'(m));
      fib_pin <= 1'b1;
      put(12'h04C, 16'h0002);
      fib_pin <= 1'b0;
      put(12'h04C, 16'h0202);
      put(12'h080, 16'h0001);
      apb(1'b0, 12'h04C, 16'h0000);
      chk(d[15:0], 16'h0002);
      put(12'h04C, 16'h0202);
      put(12'h080, 16'h0002);
      put(12'h04C, 16'h0202);
      put(12'h048, 16'h0080);
      put(12'h048, 16'h0000);
      $display("done controls");
      v = $urandom;
      put(12'h058, v[15:0]);
      put(12'h05C, v[31:16]);
      chk(sta[47:32], v[15:0]);
      chk(sta[31:16], v[31:16]);
      v = $urandom;
      put(12'h060, v[15:0]);
      chk(sta[15:0], v[15:0]);
      $display("done station address");
      put(12'h044, 16'h1000);
      pulse(4'h1);
      chk({15'h0000, irqi}, 16'h0000);
      pulse(4'h4);
      apb(1'b0, 12'h040, 16'h0000);
      chk(d[15:0], 16'h5000);
      put(12'h040, 16'hF000);
      apb(1'b0, 12'h040, 16'h0000);
      chk({irqe, irqi, d[15:2]}, 16'hC000);
      put(12'h044, 16'h0000);
      pulse(4'h1);
      chk({15'h0000, irqi}, 16'h0001);
      put(12'h044, 16'h8000);
      pulse(4'hA);
      apb(1'b0, 12'h040, 16'h0000);
      chk({irqi, d[15:1]}, 16'h5800);
      $display("done interrupt");
      complete_run();
   end
endmodule
`default_nettype wire
